//--- char_lcd_instruction_decoder.sv
/*
 Instruction decoder of a character display controller, reached as an
 Avalon-MM slave with waitrequest. Holds display RAM, user glyph RAM,
 the fixed glyph ROM and the busy timer.
 Assumes a host that polls the busy bit before each new command.
*/
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_instr_defs.svh"

// Notes on behaviour
// - Fixed glyph ROM of 240 characters, 5 by 8 dots each.
// - Writable glyph RAM holds eight user 5 by 8 characters.
// - Codes with bits 7..4 zero use glyph RAM; bit 3 ignored.
// - Code bits 2..0 become glyph RAM address bits 5..3.
// - Glyph RAM address bits 2..0 select the row.
// - Eighth row is ORed with the cursor.
// - Data bits 4..0 are the columns, bit 4 leftmost.
// - A 1 bit is a lit pixel, 0 unlit.
// - Select high means data transfer to or from addressed RAM, 18.5us.
// - Clear fills display RAM with 20H, counter 00H, increment, 0.76ms.
// - Return home zeroes counter and shift, keeps RAM, 0.76ms.
// - Entry mode stores direction and display shift enable.
// - Display control latches display, cursor and blink enables.
// - Shift moves display or cursor, right or left.
// - Function set latches bus width, line count, font height.
// - Bit 6 command loads glyph RAM address, data then targets it.
// - Bit 7 command loads display RAM address, data then targets it.
// - Status read returns busy bit and address counter at once.
// - Four-bit mode moves each byte as two nibbles.
// - Every RAM access steps the counter in entry direction.
// - Shifted entry mode shifts display on each display RAM write.
module char_lcd_instruction_decoder #(
  parameter int OSC_DIV   = `OSC_DIV_CYC,
  parameter int SHORT_OSC = `SHORT_OSC,
  parameter int LONG_OSC  = `LONG_OSC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest
);

  localparam logic [`CNT_W-1:0] DIV_LAST  = `CNT_W'(OSC_DIV - 1);
  localparam logic [`CNT_W-1:0] SHORT_CNT = `CNT_W'(SHORT_OSC);
  localparam logic [`CNT_W-1:0] LONG_CNT  = `CNT_W'(LONG_OSC);

  lcd_instr_pkg::dec_state_t st;
  lcd_instr_pkg::dec_state_t next_st;

  // Counter step with the line wrap of each layout
  function automatic logic [6:0] addr_step(input logic [6:0] a, input logic up,
                                           input logic glyph, input logic two);
    if (glyph)
      addr_step = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
    else if (two && up)
      addr_step = (a == `LINE1_END) ? `LINE2_BASE :
                  (a == `LINE2_END) ? `HOME_ADDR : a + 7'h01;
    else if (two)
      addr_step = (a == `HOME_ADDR) ? `LINE2_END :
                  (a == `LINE2_BASE) ? `LINE1_END : a - 7'h01;
    else if (up)
      addr_step = (a == `ONE_LINE_END) ? `HOME_ADDR : a + 7'h01;
    else
      addr_step = (a == `HOME_ADDR) ? `ONE_LINE_END : a - 7'h01;
  endfunction

  function automatic logic [6:0] shift_step(input logic [6:0] o, input logic right,
                                            input logic two);
    logic [6:0] last;
    last = (two ? `SHIFT_SPAN_2 : `SHIFT_SPAN_1) - 7'h01;
    if (right)
      shift_step = (o >= last) ? `HOME_ADDR : o + 7'h01;
    else
      shift_step = (o == `HOME_ADDR) ? last : o - 7'h01;
  endfunction

  // Fixed pattern set; only the space code is guaranteed blank
  function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [2:0] row);
    if (code == `SPACE_CODE || row == `ROW_CURSOR)
      rom_row = 5'h00;
    else
      rom_row = code[4:0] ^ {row, row[1:0]} ^ code[7:3];
  endfunction

  logic       request;
  logic       accept;
  logic       full_byte;
  logic [7:0] in_byte;
  logic [7:0] ram_byte;
  logic [7:0] status_byte;
  logic [4:0] pixel_row;
  logic [5:0] probe_addr;

  always_comb begin
    request     = read || write;
    accept      = request && !st.waitreq;
    full_byte   = st.bus_width_select || st.second_half;
    in_byte     = st.bus_width_select ? writedata[7:0]
                                      : {st.high_nibble, writedata[7:4]};
    ram_byte    = st.glyph_target ? st.user_glyph_ram[st.address_counter[5:0]]
                                  : st.display_ram[st.address_counter];
    status_byte = {st.busy_indicator, st.address_counter};
    probe_addr  = {st.probe_code[2:0], st.probe_row};
    if (st.probe_code[7:4] == `USER_HI_NIBBLE)
      pixel_row = st.user_glyph_ram[probe_addr][4:0];
    else
      pixel_row = rom_row(st.probe_code, st.probe_row);
    if (st.probe_row == `ROW_CURSOR && st.probe_cursor && st.cursor_on)
      pixel_row = pixel_row | 5'h1F;
    if (!st.display_on)
      pixel_row = 5'h00;
  end

  always_comb begin
    next_st = st;
    if (st.busy_indicator && st.osc_count == DIV_LAST) begin
      next_st.osc_count = '0;
      next_st.busy_count = st.busy_count - `CNT_W'(1);
      if (st.busy_count <= `CNT_W'(1))
        next_st.busy_indicator = 1'b0;
    end else if (st.busy_indicator) begin
      next_st.osc_count = st.osc_count + `CNT_W'(1);
    end

    // Answer one cycle after the request; read data prepared now
    if (request && st.waitreq) begin
      next_st.waitreq  = 1'b0;
      next_st.readdata = 32'h0000_0000;
      if (read) begin
        case (address)
          `OFS_CMD:   next_st.readdata[7:0] = st.bus_width_select || !st.second_half
                                            ? status_byte
                                            : {status_byte[3:0], 4'h0};
          `OFS_DATA:  next_st.readdata[7:0] = st.bus_width_select || !st.second_half
                                            ? ram_byte
                                            : {ram_byte[3:0], 4'h0};
          `OFS_STATE: next_st.readdata[23:0] = {st.shift_offset, st.font_tall, st.two_line,
                                                st.bus_width_select, st.blink_on,
                                                st.cursor_on, st.display_on,
                                                st.shift_enable, st.increment,
                                                st.glyph_target, st.busy_indicator,
                                                st.address_counter};
          `OFS_PROBE: next_st.readdata[4:0] = pixel_row;
          default:    next_st.readdata = 32'h0000_0000;
        endcase
      end
    end else begin
      next_st.waitreq = 1'b1;
    end

    // Four-bit reads pair two transfers before the counter moves
    if (accept && read && (address == `OFS_CMD || address == `OFS_DATA)
        && !st.bus_width_select)
      next_st.second_half = !st.second_half;

    // A data read occupies the controller for one short span as well
    if (accept && read && address == `OFS_DATA && full_byte) begin
      next_st.address_counter = addr_step(st.address_counter, st.increment,
                                          st.glyph_target, st.two_line);
      next_st.busy_indicator  = 1'b1;
      next_st.busy_count      = SHORT_CNT;
      next_st.osc_count       = '0;
    end

    if (accept && write && address == `OFS_PROBE) begin
      next_st.probe_code   = writedata[7:0];
      next_st.probe_row    = writedata[10:8];
      next_st.probe_cursor = writedata[11];
    end

    // Command and data writes are dropped while busy; data reads are not
    if (accept && write && byteenable[0] && !st.busy_indicator
        && (address == `OFS_CMD || address == `OFS_DATA)) begin
      if (!full_byte) begin
        next_st.high_nibble = writedata[7:4];
        next_st.second_half = 1'b1;
      end else begin
        next_st.second_half    = 1'b0;
        next_st.busy_indicator = 1'b1;
        next_st.busy_count     = SHORT_CNT;
        next_st.osc_count      = '0;
        if (address == `OFS_DATA) begin
          if (st.glyph_target)
            next_st.user_glyph_ram[st.address_counter[5:0]] = in_byte;
          else
            next_st.display_ram[st.address_counter] = in_byte;
          if (!st.glyph_target && st.shift_enable)
            next_st.shift_offset = shift_step(st.shift_offset, !st.increment,
                                              st.two_line);
          next_st.address_counter = addr_step(st.address_counter, st.increment,
                                              st.glyph_target, st.two_line);
        end else begin
          casez (in_byte)
            8'b1???_????: begin
              next_st.address_counter = in_byte[6:0];
              next_st.glyph_target    = 1'b0;
            end
            8'b01??_????: begin
              next_st.address_counter = {1'b0, in_byte[5:0]};
              next_st.glyph_target    = 1'b1;
            end
            8'b001?_????: begin
              next_st.bus_width_select = in_byte[4];
              next_st.two_line         = in_byte[3];
              next_st.font_tall        = in_byte[2];
            end
            8'b0001_????: begin
              if (in_byte[3])
                next_st.shift_offset = shift_step(st.shift_offset, in_byte[2],
                                                  st.two_line);
              else
                next_st.address_counter = addr_step(st.address_counter, in_byte[2],
                                                    st.glyph_target, st.two_line);
            end
            8'b0000_1???: begin
              next_st.display_on = in_byte[2];
              next_st.cursor_on  = in_byte[1];
              next_st.blink_on   = in_byte[0];
            end
            8'b0000_01??: begin
              next_st.increment    = in_byte[1];
              next_st.shift_enable = in_byte[0];
            end
            8'b0000_001?: begin
              next_st.address_counter = `HOME_ADDR;
              next_st.glyph_target    = 1'b0;
              next_st.shift_offset    = `HOME_ADDR;
              next_st.busy_count      = LONG_CNT;
            end
            8'b0000_0001: begin
              next_st.display_ram     = {128{`SPACE_CODE}};
              next_st.address_counter = `HOME_ADDR;
              next_st.glyph_target    = 1'b0;
              next_st.shift_offset    = `HOME_ADDR;
              next_st.increment       = 1'b1;
              next_st.busy_count      = LONG_CNT;
            end
            default: next_st.busy_indicator = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.waitreq          <= 1'b1;
      st.increment        <= 1'b1;
      st.bus_width_select <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign readdata    = st.readdata;
  assign waitrequest = st.waitreq;

  // Helpers for the checks; data_ok uses the decode's accept terms, cmd_ok also requires the eight-bit bus
  logic cmd_ok;
  logic data_ok;
  assign cmd_ok  = write && !st.waitreq && address == `OFS_CMD && byteenable[0]
                   && !st.busy_indicator && st.bus_width_select;
  assign data_ok = accept && write && address == `OFS_DATA && byteenable[0]
                   && !st.busy_indicator && full_byte;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Bus handshake
  chk_wait_answer: assert property (request && st.waitreq |=> !waitrequest)
    else $error("waitrequest did not drop after one cycle");

  chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest stayed low");

  chk_status_read: assert property (read && st.waitreq && address == `OFS_CMD
    && st.bus_width_select |=> readdata[7:0] == $past(status_byte))
    else $error("status read mismatch");

  chk_status_nibble: assert property (read && st.waitreq && address == `OFS_CMD
    && !st.bus_width_select && st.second_half
    |=> readdata[7:4] == $past(st.address_counter[3:0]))
    else $error("second status nibble mismatch");

  // Busy timing; counts are parameters, so no fixed span is assumed here
  chk_busy_hold: assert property (st.busy_indicator && st.busy_count > `CNT_W'(1)
    |=> st.busy_indicator)
    else $error("busy ended before its count ran out");

  chk_data_busy: assert property (data_ok
    |=> st.busy_indicator && st.busy_count == SHORT_CNT)
    else $error("data write did not start a short busy span");

  chk_clear_busy: assert property (cmd_ok && writedata[7:0] == 8'h01
    |=> st.busy_indicator && st.busy_count == LONG_CNT)
    else $error("clear did not start a long busy span");

  chk_home_busy: assert property (cmd_ok && writedata[7:1] == 7'h01
    |=> st.busy_indicator && st.busy_count == LONG_CNT)
    else $error("return home did not start a long busy span");

  chk_busy_refuse: assert property (accept && write && st.busy_indicator
    && address == `OFS_CMD |=> st.address_counter == $past(st.address_counter))
    else $error("command taken while busy");

  // Command decode
  chk_clear_fill: assert property (cmd_ok && writedata[7:0] == 8'h01 |=>
    st.display_ram[5] == `SPACE_CODE && st.address_counter == `HOME_ADDR && st.increment)
    else $error("clear incomplete");

  chk_home_addr: assert property (cmd_ok && writedata[7:1] == 7'h01 |=>
    st.address_counter == `HOME_ADDR && st.shift_offset == `HOME_ADDR)
    else $error("return home incomplete");

  chk_entry_mode: assert property (cmd_ok && writedata[7:2] == 6'h01 |=>
    st.increment == $past(writedata[1]) && st.shift_enable == $past(writedata[0]))
    else $error("entry mode not stored");

  chk_display_ctl: assert property (cmd_ok && writedata[7:3] == 5'h01 |=>
    st.display_on == $past(writedata[2]) && st.blink_on == $past(writedata[0]))
    else $error("display control not stored");

  chk_func_set: assert property (cmd_ok && writedata[7:5] == 3'h1 |=>
    st.two_line == $past(writedata[3]) && st.font_tall == $past(writedata[2]))
    else $error("function set not stored");

  chk_glyph_addr: assert property (cmd_ok && writedata[7:6] == 2'h1 |=>
    st.glyph_target && st.address_counter[5:0] == $past(writedata[5:0]))
    else $error("glyph address not loaded");

  chk_ram_addr: assert property (cmd_ok && writedata[7] |=>
    !st.glyph_target && st.address_counter == $past(writedata[6:0]))
    else $error("display address not loaded");

  chk_shift_keep: assert property (cmd_ok && writedata[7:3] == 5'h03
    |=> st.address_counter == $past(st.address_counter))
    else $error("display shift moved the counter");

  chk_func_width: assert property (cmd_ok && writedata[7:5] == 3'h1
    |=> st.bus_width_select == $past(writedata[4]))
    else $error("bus width not stored");

  // Data path
  chk_glyph_step: assert property (data_ok && st.glyph_target && st.increment
    |=> st.address_counter[5:0] == $past(st.address_counter[5:0]) + 6'h01)
    else $error("glyph counter did not step");

  chk_glyph_store: assert property (data_ok && st.glyph_target
    |=> st.user_glyph_ram[$past(st.address_counter[5:0])] == $past(in_byte))
    else $error("glyph row not stored");

  chk_entry_shift: assert property (data_ok && !st.glyph_target && st.shift_enable
    |=> st.shift_offset != $past(st.shift_offset))
    else $error("display did not shift on write");

  // Glyph probe
  chk_cursor_row: assert property (read && st.waitreq && address == `OFS_PROBE
    && st.display_on && st.cursor_on && st.probe_cursor && st.probe_row == `ROW_CURSOR
    |=> readdata[4:0] == 5'h1F)
    else $error("cursor row not lit");

  chk_blank_off: assert property (read && st.waitreq && address == `OFS_PROBE
    && !st.display_on |=> readdata[4:0] == 5'h00)
    else $error("pixels lit with display off");

endmodule // char_lcd_instruction_decoder

`default_nettype wire

//--- char_lcd_instruction_decoder_tb.sv
/*
 Self-checking bench of the instruction decoder, driven through the host
 model. Assumes shortened oscillator counts so busy spans stay small.
*/
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_decoder_tb;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  int          bad_count = 0;
  int          checked   = 0;
  logic [7:0]  b;
  logic [31:0] q;
  int          pl;
  int          ps;
  logic [7:0]  rows [8] = '{8'hEE, 8'h11, 8'h11, 8'h1F, 8'h11, 8'h11, 8'h11, 8'h00};

  always #2 ref_clk = ~ref_clk;

  char_lcd_instruction_decoder #(.OSC_DIV(2), .SHORT_OSC(2), .LONG_OSC(4)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  host_bus_model i_host (
    .ref_clk(ref_clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic state(output logic [31:0] s);
    i_host.xfer(4'h8, 1'b0, 32'h0, 4'hF, s);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("[ERR] watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    i_host.get_byte(4'h0, b);
    chk("status", 32'h00, b);
    state(q);
    chk("state", 32'h004200, q[23:0]);
    $display("test reset done");

    i_host.issue(4'h0, 8'h01);
    i_host.get_byte(4'h0, b);
    chk("busy after clear", 32'h1, b[7]);
    i_host.wait_ready(pl);
    i_host.issue(4'h4, 8'h55);
    i_host.get_byte(4'h0, b);
    chk("busy after data", 32'h1, b[7]);
    i_host.wait_ready(ps);
    chk("long over short", 32'h1, pl > ps);
    i_host.issue(4'h0, 8'h80);
    i_host.fetch(4'h4, b);
    chk("data read", 32'h55, b);
    i_host.get_byte(4'h0, b);
    chk("busy after read", 32'h1, b[7]);
    i_host.fetch(4'h4, b);
    chk("cleared cell", 32'h20, b);
    i_host.fetch(4'h0, b);
    chk("counter", 32'h02, b);
    $display("test clear done");

    i_host.issue(4'h0, 8'h01);
    i_host.put_byte(4'h0, 8'h85);
    // Idle again, so only the disabled byte lane can stop this one
    i_host.wait_ready(ps);
    i_host.xfer(4'h0, 1'b1, 32'h86, 4'h0, q);
    i_host.fetch(4'h0, b);
    chk("refused", 32'h00, b);
    $display("test refuse done");

    i_host.issue(4'h0, 8'h04);
    i_host.issue(4'h0, 8'h90);
    i_host.issue(4'h4, 8'h41);
    i_host.fetch(4'h0, b);
    chk("decrement", 32'h0F, b);
    i_host.issue(4'h0, 8'h14);
    i_host.fetch(4'h0, b);
    chk("cursor right", 32'h10, b);
    i_host.issue(4'h0, 8'h10);
    i_host.issue(4'h0, 8'h1C);
    i_host.fetch(4'h0, b);
    chk("shift keeps counter", 32'h0F, b);
    state(q);
    chk("display shifted", 32'h1, q[23:17] !== 7'h00);
    i_host.issue(4'h0, 8'h03);
    i_host.fetch(4'h0, b);
    chk("home counter", 32'h00, b);
    state(q);
    chk("home offset", 32'h00, q[23:17]);
    i_host.issue(4'h0, 8'h90);
    i_host.fetch(4'h4, b);
    chk("home keeps ram", 32'h41, b);
    i_host.issue(4'h0, 8'h07);
    i_host.issue(4'h4, 8'h42);
    state(q);
    chk("entry shift", 32'h1, q[23:17] !== 7'h00);
    i_host.issue(4'h0, 8'h06);
    $display("test motion done");

    i_host.issue(4'h0, 8'h0F);
    i_host.issue(4'h0, 8'h3C);
    state(q);
    chk("control bits", 32'h3F, q[16:11]);
    i_host.issue(4'h0, 8'h0A);
    state(q);
    chk("cursor only", 32'h3A, q[16:11]);
    $display("test control done");

    i_host.issue(4'h0, 8'h58);
    state(q);
    chk("glyph target", 32'h1, q[8]);
    for (int i = 0; i < 8; i++) i_host.issue(4'h4, rows[i]);
    i_host.fetch(4'h0, b);
    chk("glyph counter", 32'h20, b);
    i_host.issue(4'h0, 8'h0E);
    // Bit 3 of the code must not matter
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        i_host.xfer(4'hC, 1'b1, {20'h0, 1'b0, 3'(i), 4'h0, 1'(c), 3'h3}, 4'hF, q);
        i_host.xfer(4'hC, 1'b0, 32'h0, 4'hF, q);
        chk("glyph row", {27'h0, rows[i][4:0]}, q[4:0]);
      end
    end
    i_host.xfer(4'hC, 1'b1, 32'h00000F03, 4'hF, q);
    i_host.xfer(4'hC, 1'b0, 32'h0, 4'hF, q);
    chk("cursor row", 32'h1F, q[4:0]);
    i_host.xfer(4'hC, 1'b1, 32'h00000020, 4'hF, q);
    i_host.xfer(4'hC, 1'b0, 32'h0, 4'hF, q);
    chk("rom space", 32'h00, q[4:0]);
    i_host.issue(4'h0, 8'h08);
    i_host.xfer(4'hC, 1'b1, 32'h00000003, 4'hF, q);
    i_host.xfer(4'hC, 1'b0, 32'h0, 4'hF, q);
    chk("display off row", 32'h00, q[4:0]);
    $display("test glyph done");

    i_host.issue(4'h0, 8'h28);
    i_host.issue(4'h0, 8'hC5);
    i_host.wait_ready(ps);
    i_host.xfer(4'h0, 1'b0, 32'h0, 4'hF, q);
    chk("high nibble", 32'h4, q[7:4]);
    i_host.xfer(4'h0, 1'b0, 32'h0, 4'hF, q);
    chk("low nibble", 32'h5, q[7:4]);
    i_host.issue(4'h0, 8'h30);
    i_host.fetch(4'h0, b);
    chk("wide again", 32'h45, b);
    $display("test narrow done");
    wrap_up();
  end
endmodule // char_lcd_instruction_decoder_tb
`default_nettype wire

//--- host_bus_model.sv
/*
 Host processor model: an Avalon-MM master issuing commands, data and
 status polls to the decoder. Assumes it shares the decoder's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic        ref_clk,
  output logic      [3:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  logic nibble_mode;

  initial begin
    address     = 4'h0;
    read        = 1'b0;
    write       = 1'b0;
    writedata   = 32'h0;
    byteenable  = 4'hF;
    nibble_mode = 1'b0;
  end

  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge ref_clk);
    address    <= a;
    read       <= ~w;
    write      <= w;
    writedata  <= d;
    byteenable <= be;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // High nibble first on the narrow bus
  task automatic put_byte(input logic [3:0] a, input logic [7:0] b);
    logic [31:0] q;
    if (nibble_mode) begin
      xfer(a, 1'b1, {24'h0, b[7:4], 4'h0}, 4'hF, q);
      xfer(a, 1'b1, {24'h0, b[3:0], 4'h0}, 4'hF, q);
    end else begin
      xfer(a, 1'b1, {24'h0, b}, 4'hF, q);
    end
  endtask

  task automatic get_byte(input logic [3:0] a, output logic [7:0] b);
    logic [31:0] q1;
    logic [31:0] q2;
    xfer(a, 1'b0, 32'h0, 4'hF, q1);
    if (nibble_mode) begin
      xfer(a, 1'b0, 32'h0, 4'hF, q2);
      b = {q1[7:4], q2[7:4]};
    end else begin
      b = q1[7:0];
    end
  endtask

  // Bounded at 5000 polls so a stuck busy bit cannot hold the bench here forever
  task automatic wait_ready(output int polls);
    logic [7:0] s;
    polls = 0;
    do begin
      get_byte(4'h0, s);
      polls++;
    end while (s[7] !== 1'b0 && polls < 5000);
  endtask

  task automatic issue(input logic [3:0] a, input logic [7:0] b);
    int p;
    wait_ready(p);
    put_byte(a, b);
    if (a == 4'h0 && b[7:5] == 3'b001) nibble_mode = ~b[4];
  endtask

  task automatic fetch(input logic [3:0] a, output logic [7:0] b);
    int p;
    wait_ready(p);
    get_byte(a, b);
  endtask
endmodule // host_bus_model
`default_nettype wire

//--- lcd_instr_defs.svh
/*
 Constants of the character display instruction decoder: bus offsets,
 codes, address limits and execution times. Included by the package
 and the decoder; holds definitions only.
*/
`ifndef LCD_INSTR_DEFS_SVH
`define LCD_INSTR_DEFS_SVH

`define OFS_CMD        4'h0
`define OFS_DATA       4'h4
`define OFS_STATE      4'h8
`define OFS_PROBE      4'hC

`define SPACE_CODE     8'h20
`define HOME_ADDR      7'h00
`define ONE_LINE_END   7'h4F
`define LINE1_END      7'h27
`define LINE2_BASE     7'h40
`define LINE2_END      7'h67
`define SHIFT_SPAN_1   7'h50
`define SHIFT_SPAN_2   7'h28
`define ROW_CURSOR     3'h7
`define USER_HI_NIBBLE 4'h0

`define REF_KHZ        250000
`define OSC_KHZ        540
`define T_SHORT_NS     18500
`define T_LONG_NS      760000
`define OSC_DIV_CYC    (`REF_KHZ / `OSC_KHZ)
`define SHORT_OSC      ((`T_SHORT_NS * `OSC_KHZ + 999999) / 1000000)
`define LONG_OSC       ((`T_LONG_NS * `OSC_KHZ + 999999) / 1000000)
`define CNT_W          16

`endif

//--- lcd_instr_pkg.sv
/*
 Types of the character display instruction decoder.
 Assumes lcd_instr_defs.svh is on the include path.
*/
`default_nettype none
`include "lcd_instr_defs.svh"

package lcd_instr_pkg;

  typedef struct packed {
    logic                  waitreq;
    logic [31:0]           readdata;
    logic [6:0]            address_counter;
    logic                  glyph_target;
    logic                  increment;
    logic                  shift_enable;
    logic                  display_on;
    logic                  cursor_on;
    logic                  blink_on;
    logic                  bus_width_select;
    logic                  two_line;
    logic                  font_tall;
    logic [6:0]            shift_offset;
    logic                  second_half;
    logic [3:0]            high_nibble;
    logic                  busy_indicator;
    logic [`CNT_W-1:0]     busy_count;
    logic [`CNT_W-1:0]     osc_count;
    logic [7:0]            probe_code;
    logic [2:0]            probe_row;
    logic                  probe_cursor;
    logic [127:0][7:0]     display_ram;
    logic [63:0][7:0]      user_glyph_ram;
  } dec_state_t;

endpackage

`default_nettype wire
